// [core/two_wire_slave.sv]
// Behaviour
// - start in sleep holds clock low
// - clock running releases stretch, receive byte
// - only slave clocked during wake byte
// - address match in sleep requests full wakeup
// - no match returns to previous sleep
// - byte sent clears thr, sets btf
// - ack after received byte from control
// - byte received sets rhr, btf
// - other slave address changes no flags
// - disabled match takes no action
// - enabled match sets flag, enters direction
// - direction flag one cycle after match
// - stretch after address ack until cleared
// - repeated start sets rep only
// - stop sets stop and transfer_complete
`include "tws_consts.svh"
module two_wire_slave (
   input  wire logic        sys_clk_i,
   input  wire logic        resetn_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             scl_oe_n_o,
   output logic             sda_oe_n_o,
   input  wire logic        clock_running_i,
   output logic             clock_request_o,
   output logic             wake_request_o,
   output logic             partial_clock_o,
   output logic             irq_o
);

   typedef struct packed {
      tws_pkg::phase_t        phase;
      logic [5:0]             ctrl;
      logic [`ST_WIDTH-1:0]   status;
      logic [`ST_WIDTH-1:0]   mask;
      logic [7:0]             txdata;
      logic [7:0]             rxdata;
      logic [6:0]             own_adr;
      logic [7:0]             shift;
      logic [3:0]             bitcnt;
      logic                   addressed;
      logic                   tra_pend;
      logic                   tra_val;
      logic                   rx_dir;
      logic                   sleep_wake;
      logic                   scl_prev;
      logic                   sda_prev;
      logic                   scl_hold;
      logic                   sda_low;
      logic                   clk_req;
      logic                   wake_req;
      logic                   part_clk;
      logic                   irq;
      logic [31:0]            prdata;
      logic                   pready;
      logic                   pslverr;
   } state_t;

   state_t st_reg;
   state_t st_next;
   logic [1:0] pins_sync;
   logic       scl_s;
   logic       sda_s;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_ev;
   logic       stop_ev;
   logic       acc;
   logic       last_bit;

   sync_2ff #(
      .WIDTH (2)
   ) u_sync (
      .sys_clk_i (sys_clk_i),
      .resetn_i  (resetn_i),
      .d_i       ({scl_i, sda_i}),
      .q_o       (pins_sync)
   );

   assign scl_s    = pins_sync[1];
   assign sda_s    = pins_sync[0];
   assign scl_rise = scl_s & ~st_reg.scl_prev;
   assign scl_fall = ~scl_s & st_reg.scl_prev;
   assign start_ev = scl_s & st_reg.scl_prev & st_reg.sda_prev & ~sda_s;
   assign stop_ev  = scl_s & st_reg.scl_prev & ~st_reg.sda_prev & sda_s;
   assign acc      = psel_i & penable_i & ~st_reg.pready;
   assign last_bit = st_reg.bitcnt == 4'h7;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = a == off;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      st_next          = st_reg;
      st_next.scl_prev = scl_s;
      st_next.sda_prev = sda_s;
      st_next.pready   = 1'b0;
      st_next.pslverr  = 1'b0;

      // read clears first, so events further down win
      if (acc && !pwrite_i && hit(paddr_i, `ADDR_STATUS))
      begin
         st_next.status          = '0;
         st_next.status[`ST_THR] = st_reg.status[`ST_THR];
         st_next.status[`ST_TRA] = st_reg.status[`ST_TRA] &
                                   st_reg.addressed;
      end
      else if (acc && !pwrite_i && hit(paddr_i, `ADDR_RXDATA))
         st_next.status[`ST_RHR] = 1'b0;

      // transfer direction lags the match bit by one cycle
      if (st_reg.tra_pend)
      begin
         st_next.status[`ST_TRA] = st_reg.tra_val;
         st_next.tra_pend        = 1'b0;
      end

      if (!st_reg.ctrl[`CTRL_ENABLE])
      begin
         st_next.phase    = tws_pkg::S_IDLE;
         st_next.scl_hold = 1'b0;
         st_next.sda_low  = 1'b0;
      end
      else if (stop_ev)
      begin
         if (st_reg.addressed)
         begin
            st_next.status[`ST_STOP]  = 1'b1;
            st_next.status[`ST_TRANSFER_COMPLETE] = 1'b1;
         end
         st_next.addressed = 1'b0;
         st_next.sda_low   = 1'b0;
         st_next.phase     = tws_pkg::S_IDLE;
      end
      else if (start_ev)
      begin
         if (st_reg.addressed)
            st_next.status[`ST_REP] = 1'b1;
         st_next.addressed = 1'b0;
         st_next.bitcnt    = 4'h0;
         st_next.sda_low   = 1'b0;
         if (st_reg.ctrl[`CTRL_SLEEP] && !clock_running_i)
         begin
            st_next.scl_hold   = 1'b1;
            st_next.clk_req    = 1'b1;
            st_next.part_clk   = 1'b1;
            st_next.sleep_wake = 1'b1;
            st_next.phase      = tws_pkg::S_WAKE;
         end
         else
            st_next.phase = tws_pkg::S_ADDR;
      end
      else
      begin
         case (st_reg.phase)
            tws_pkg::S_IDLE:
               st_next.scl_hold = 1'b0;
            tws_pkg::S_WAKE:
               if (clock_running_i)
               begin
                  st_next.scl_hold = 1'b0;
                  st_next.phase    = tws_pkg::S_ADDR;
               end
            tws_pkg::S_ADDR:
               if (scl_rise)
               begin
                  st_next.shift  = {st_reg.shift[6:0], sda_s};
                  st_next.bitcnt = st_reg.bitcnt + 4'h1;
               end
               else if (scl_fall && st_reg.bitcnt == 4'h8)
               begin
                  st_next.bitcnt = 4'h0;
                  if (st_reg.shift[7:1] == st_reg.own_adr &&
                      st_reg.ctrl[`CTRL_MATCH_EN])
                  begin
                     st_next.status[`ST_MATCH] = 1'b1;
                     st_next.tra_pend  = 1'b1;
                     st_next.tra_val   = st_reg.shift[0];
                     st_next.rx_dir    = ~st_reg.shift[0];
                     st_next.addressed = 1'b1;
                     st_next.sda_low   = 1'b1;
                     st_next.phase     = tws_pkg::S_ACK_RX;
                     if (st_reg.sleep_wake)
                     begin
                        st_next.wake_req   = 1'b1;
                        st_next.part_clk   = 1'b0;
                        st_next.sleep_wake = 1'b0;
                     end
                  end
                  else
                  begin
                     // foreign or disabled address: flags untouched
                     st_next.phase = tws_pkg::S_IGNORE;
                     if (st_reg.sleep_wake)
                     begin
                        st_next.clk_req    = 1'b0;
                        st_next.part_clk   = 1'b0;
                        st_next.sleep_wake = 1'b0;
                     end
                  end
               end
            tws_pkg::S_ACK_RX:
               // address ack or data ack driven by us
               if (scl_fall)
               begin
                  st_next.sda_low = 1'b0;
                  if (st_reg.ctrl[`CTRL_STRETCH] &&
                      st_reg.ctrl[`CTRL_STRETCH_ON_ADDRESS_MATCH] &&
                      st_reg.status[`ST_MATCH])
                     st_next.scl_hold = 1'b1;
                  if (st_reg.rx_dir)
                     st_next.phase = tws_pkg::S_RX;
                  else
                  begin
                     st_next.phase   = tws_pkg::S_TX;
                     st_next.shift   = st_reg.txdata;
                     st_next.sda_low = ~st_reg.txdata[7];
                  end
               end
            tws_pkg::S_RX:
               if (!st_reg.status[`ST_MATCH] || !st_reg.scl_hold)
               begin
                  st_next.scl_hold = 1'b0;
                  if (scl_rise)
                  begin
                     st_next.shift  = {st_reg.shift[6:0], sda_s};
                     st_next.bitcnt = st_reg.bitcnt + 4'h1;
                  end
                  else if (scl_fall && st_reg.bitcnt == 4'h8)
                  begin
                     st_next.bitcnt           = 4'h0;
                     st_next.rxdata           = st_reg.shift;
                     st_next.status[`ST_RHR]  = 1'b1;
                     st_next.status[`ST_BTF]  = 1'b1;
                     st_next.sda_low = st_reg.ctrl[`CTRL_ACK];
                     st_next.phase   = tws_pkg::S_ACK_RX;
                  end
               end
            tws_pkg::S_TX:
               if (!st_reg.status[`ST_MATCH] || !st_reg.scl_hold)
               begin
                  st_next.scl_hold = 1'b0;
                  if (scl_fall)
                  begin
                     st_next.bitcnt = st_reg.bitcnt + 4'h1;
                     st_next.shift  = {st_reg.shift[6:0], 1'b1};
                     if (last_bit)
                     begin
                        st_next.status[`ST_THR] = 1'b0;
                        st_next.status[`ST_BTF] = 1'b1;
                        st_next.sda_low = 1'b0;  // master acks here
                        st_next.phase   = tws_pkg::S_ACK_TX;
                     end
                     else
                        st_next.sda_low = ~st_reg.shift[6];
                  end
               end
            tws_pkg::S_ACK_TX:
               if (scl_rise)
               begin
                  st_next.status[`ST_NAK] = sda_s;
                  st_next.bitcnt          = 4'h0;
               end
               else if (scl_fall)
               begin
                  if (st_reg.status[`ST_NAK])
                     st_next.phase = tws_pkg::S_IGNORE;
                  else
                  begin
                     st_next.shift   = st_reg.txdata;
                     st_next.sda_low = ~st_reg.txdata[7];
                     st_next.phase   = tws_pkg::S_TX;
                  end
               end
            default:
               st_next.sda_low = 1'b0;
         endcase
      end

      // drop clock request once running normally; wake request stays set
      if (st_reg.wake_req && clock_running_i && !st_reg.sleep_wake)
         st_next.clk_req = 1'b0;

      // apb slave: one wait state, reads of status clear it except thr, and tra while addressed
      if (acc)
      begin
         st_next.pready = 1'b1;
         st_next.prdata = 32'h0000_0000;
         if (pwrite_i)
         begin
            if (hit(paddr_i, `ADDR_CTRL))
               st_next.ctrl = pwdata_i[5:0];
            else if (hit(paddr_i, `ADDR_MASK))
               st_next.mask = pwdata_i[`ST_WIDTH-1:0];
            else if (hit(paddr_i, `ADDR_TXDATA))
            begin
               st_next.txdata          = pwdata_i[7:0];
               st_next.status[`ST_THR] = 1'b1;
            end
            else if (hit(paddr_i, `ADDR_OWNADR))
               st_next.own_adr = pwdata_i[6:0];
            else if (!hit(paddr_i, `ADDR_STATUS) &&
                     !hit(paddr_i, `ADDR_RXDATA))
               st_next.pslverr = 1'b1;
         end
         else
         begin
            if (hit(paddr_i, `ADDR_CTRL))
               st_next.prdata = {26'h0, st_reg.ctrl};
            else if (hit(paddr_i, `ADDR_STATUS))
               st_next.prdata = {23'h0, st_reg.status};
            else if (hit(paddr_i, `ADDR_MASK))
               st_next.prdata = {23'h0, st_reg.mask};
            else if (hit(paddr_i, `ADDR_TXDATA))
               st_next.prdata = {24'h0, st_reg.txdata};
            else if (hit(paddr_i, `ADDR_RXDATA))
               st_next.prdata = {24'h0, st_reg.rxdata};
            else if (hit(paddr_i, `ADDR_OWNADR))
               st_next.prdata = {25'h0, st_reg.own_adr};
            else
               st_next.pslverr = 1'b1;
         end
      end

      st_next.irq = |(st_next.status & st_next.mask &
                      ~(`ST_WIDTH'(1) << `ST_TRA));
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         st_reg          <= '0;
         st_reg.phase    <= tws_pkg::S_IDLE;
         st_reg.own_adr  <= `OWNADR_RESET;
         st_reg.scl_prev <= 1'b1;
         st_reg.sda_prev <= 1'b1;
      end
      else
         st_reg <= st_next;
   end

   assign prdata_o        = st_reg.prdata;
   assign pready_o        = st_reg.pready;
   assign pslverr_o       = st_reg.pslverr;
   assign scl_oe_n_o      = ~st_reg.scl_hold;
   assign sda_oe_n_o      = ~st_reg.sda_low;
   assign clock_request_o = st_reg.clk_req;
   assign wake_request_o  = st_reg.wake_req;
   assign partial_clock_o = st_reg.part_clk;
   assign irq_o           = st_reg.irq;

endmodule

// [pkg/tws_consts.svh]
`ifndef TWS_CONSTS_SVH
`define TWS_CONSTS_SVH

`define ADDR_CTRL      8'h00
`define ADDR_STATUS    8'h04
`define ADDR_MASK      8'h08
`define ADDR_TXDATA    8'h0c
`define ADDR_RXDATA    8'h10
`define ADDR_OWNADR    8'h14

`define CTRL_ENABLE    0
`define CTRL_MATCH_EN  1
`define CTRL_ACK       2
`define CTRL_STRETCH   3
`define CTRL_STRETCH_ON_ADDRESS_MATCH      4
`define CTRL_SLEEP     5

`define ST_THR         0
`define ST_RHR         1
`define ST_BTF         2
`define ST_NAK         3
`define ST_MATCH       4
`define ST_TRA         5
`define ST_REP         6
`define ST_STOP        7
`define ST_TRANSFER_COMPLETE       8
`define ST_WIDTH       9

`define OWNADR_RESET   7'h2a
`define WAKE_DELAY     4'h4

`endif

// [pkg/tws_pkg.sv]
package tws_pkg;

   typedef enum logic [2:0] {
      S_IDLE,
      S_WAKE,
      S_ADDR,
      S_RX,
      S_TX,
      S_ACK_TX,
      S_ACK_RX,
      S_IGNORE
   } phase_t;

   typedef struct packed {
      logic       psel;
      logic       penable;
      logic       pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic        scl_oe_n;
      logic        sda_oe_n;
   } pin_drive_t;

endpackage

// [core/sync_2ff.sv]
module sync_2ff #(
   parameter int WIDTH = 2
)(
   input  wire logic             sys_clk_i,
   input  wire logic             resetn_i,
   input  wire logic [WIDTH-1:0] d_i,
   output logic      [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_reg;

   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         meta_reg <= '1;
         q_o      <= '1;
      end
      else
      begin
         meta_reg <= d_i;
         q_o      <= meta_reg;
      end
   end
endmodule

// [testbench/two_wire_slave_assertions.sv]
module slave_checker (
   input wire logic        sys_clk_i,
   input wire logic        resetn_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [7:0]  paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   input wire logic        scl_i,
   input wire logic        sda_i,
   input wire logic        scl_oe_n_o,
   input wire logic        sda_oe_n_o,
   input wire logic        clock_running_i,
   input wire logic        clock_request_o,
   input wire logic        wake_request_o,
   input wire logic        partial_clock_o,
   input wire logic        irq_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic acc;
   assign acc = psel_i & penable_i;
   default clocking @(posedge sys_clk_i);
   endclocking
   default disable iff (!resetn_i);
   ////////////////////////////////////////
   pready_pulse_a: assert property (pready_o |=> !pready_o)
      else $error("pready longer than one cycle");
   apb_answer_a: assert property (acc && !pready_o |=> pready_o)
      else $error("no answer one cycle after access");
   slverr_qual_a: assert property (pslverr_o |-> pready_o)
      else $error("slverr without pready");
   sleep_hold_a: assert property (
      clock_request_o && $past(clock_request_o) && !clock_running_i
      |-> !scl_oe_n_o) else $error("clock line not held in sleep");
   wake_release_a: assert property (
      $rose(clock_running_i) && clock_request_o |-> ##[1:4] scl_oe_n_o)
      else $error("clock line not released after restart");
   request_partial_a: assert property (
      $rose(clock_request_o) |-> partial_clock_o)
      else $error("partial clock missing with restart request");
   wake_sticky_a: assert property (
      $past(wake_request_o) |-> wake_request_o)
      else $error("wake request dropped");
   irq_clear_a: assert property (
      $fell(irq_o) |-> $past(acc) || $past(acc, 2) || $past(acc, 3))
      else $error("irq fell without register access");
   cover property ($rose(wake_request_o));
   cover property ($rose(irq_o));
   cover property (pslverr_o);
endmodule
bind two_wire_slave slave_checker i_slave_checker (.*);

// [testbench/wire_master.sv]
module wire_master (
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      scl_oe_n_o,
   output logic      sda_oe_n_o
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int HP = 160;
   int stuck = 0;
   initial
   begin
      scl_oe_n_o = 1'b1;
      sda_oe_n_o = 1'b1;
   end
   ////////////////////////////////////////
   // release clock, wait out a stretch of up to 4000 polls of 10 ns
   task automatic rise();
      int n;
      n = 0;
      scl_oe_n_o = 1'b1;
      while (scl_i !== 1'b1 && n < 4000)
      begin
         #10;
         n++;
      end
      stuck += int'(n == 4000);
      #HP;
   endtask
   // data read back at end of high phase
   task automatic bit_io(input logic b, output logic r);
      #(HP / 2);
      sda_oe_n_o = b;
      #(HP / 2);
      rise();
      r = sda_i;
      scl_oe_n_o = 1'b0;
   endtask
   task automatic start();
      #(HP / 2);
      sda_oe_n_o = 1'b1;
      #(HP / 2);
      rise();
      sda_oe_n_o = 1'b0;
      #HP;
      scl_oe_n_o = 1'b0;
   endtask
   task automatic stop();
      #(HP / 2);
      sda_oe_n_o = 1'b0;
      #(HP / 2);
      rise();
      sda_oe_n_o = 1'b1;
      #HP;
   endtask
   task automatic xfer(input logic [7:0] d, input logic ak,
                       output logic [7:0] q, output logic a);
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], q[i]);
      bit_io(ak, a);
   endtask
endmodule

// [testbench/two_wire_slave_bench.sv]
`include "tws_consts.svh"
module two_wire_slave_bench;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic        w;
      logic [7:0]  a;
      logic [31:0] d;
      logic        e;
   } row_t;
   logic                 sys_clk = 1'b0;
   logic                 resetn = 1'b0;
   logic                 crun = 1'b1;
   tws_pkg::apb_req_t    req = '0;
   wire tws_pkg::pin_drive_t s_drv, m_drv;
   logic [31:0]          prdata;
   logic                 pready, pslverr, irq, creq, wreq, pclk;
   wire                  scl = s_drv.scl_oe_n & m_drv.scl_oe_n;
   wire                  sda = s_drv.sda_oe_n & m_drv.sda_oe_n;
   int                   err_total = 0;
   int                   checks = 0;
   row_t                 rows [8] = '{
      '{1'b0, `ADDR_CTRL, 32'h0, 1'b0}, '{1'b0, `ADDR_STATUS, 32'h0, 1'b0},
      '{1'b0, `ADDR_MASK, 32'h0, 1'b0}, '{1'b0, `ADDR_OWNADR, 32'h2a, 1'b0},
      '{1'b1, `ADDR_CTRL, 32'h1f, 1'b0}, '{1'b0, `ADDR_CTRL, 32'h1f, 1'b0},
      '{1'b1, 8'h1c, 32'hff, 1'b1}, '{1'b0, 8'h18, 32'h0, 1'b1}};
   always #20 sys_clk = ~sys_clk;
   two_wire_slave i_two_wire_slave (
      .sys_clk_i(sys_clk), .resetn_i(resetn), .psel_i(req.psel),
      .penable_i(req.penable), .pwrite_i(req.pwrite), .paddr_i(req.paddr),
      .pwdata_i(req.pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .scl_i(scl), .sda_i(sda),
      .scl_oe_n_o(s_drv.scl_oe_n), .sda_oe_n_o(s_drv.sda_oe_n),
      .clock_running_i(crun), .clock_request_o(creq),
      .wake_request_o(wreq), .partial_clock_o(pclk), .irq_o(irq));
   wire_master i_wire_master (.scl_i(scl), .sda_i(sda),
      .scl_oe_n_o(m_drv.scl_oe_n), .sda_oe_n_o(m_drv.sda_oe_n));
   ////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] x, g);
      checks++;
      if (g !== x)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      int n;
      @(posedge sys_clk);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge sys_clk);
      req.penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n == 20)
      begin
         err_total++;
         end_sim();
      end
      q = prdata;
      e = pslverr;
      req <= '0;
      @(posedge sys_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd(input string nm, input logic [7:0] a,
                     input logic [31:0] x, m);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      chk(nm, x & m, q & m);
   endtask
   task automatic addr(input logic [7:0] b, input logic ea);
      logic [7:0] q;
      logic       a;
      i_wire_master.start();
      i_wire_master.xfer(b, 1'b1, q, a);
      chk("addr ack", {31'h0, ea}, {31'h0, a});
   endtask
   task automatic sleep_addr(input logic [7:0] b, input logic ea);
      int n;
      wr(`ADDR_CTRL, 32'h27);
      crun <= 1'b0;
      fork
         addr(b, ea);
         begin
            n = 0;
            while (creq !== 1'b1 && n < 100)
            begin
               @(posedge sys_clk);
               n++;
            end
            if (n == 100)
            begin
               err_total++;
               end_sim();
            end
            repeat (10) @(posedge sys_clk);
            chk("sleep scl", 32'h0, {31'h0, scl});
            chk("partial", 32'h1, {31'h0, pclk});
            crun <= 1'b1;
         end
      join
      i_wire_master.stop();
      repeat (4) @(posedge sys_clk);
      chk("wake", {31'h0, ~ea}, {31'h0, wreq});
   endtask
   ////////////////////////////////////////
   initial
   begin
      logic [31:0] q;
      logic        e;
      logic [7:0]  q8;
      logic        a;
      repeat (3) @(posedge sys_clk);
      resetn <= 1'b1;
      foreach (rows[i])
      begin
         apb(rows[i].w, rows[i].a, rows[i].d, q, e);
         chk("slverr", {31'h0, rows[i].e}, {31'h0, e});
         if (!rows[i].w && !rows[i].e)
            chk("rdata", rows[i].d, q);
      end
      $display("test registers done");
      for (int k = 0; k < 2; k++)
      begin
         wr(`ADDR_CTRL, (k == 1) ? 32'h05 : 32'h07);
         addr((k == 1) ? 8'h54 : 8'h2a, 1'b1);
         i_wire_master.stop();
         rd("quiet", `ADDR_STATUS, 32'h0, 32'h1ff);
      end
      $display("test ignored addresses done");
      sleep_addr(8'h2a, 1'b1);
      chk("back asleep", 32'h0, {31'h0, creq | pclk});
      crun <= 1'b0;
      sleep_addr(8'h54, 1'b0);
      $display("test sleep wake done");
      wr(`ADDR_CTRL, 32'h07);
      apb(1'b0, `ADDR_STATUS, 32'h0, q, e);
      wr(`ADDR_MASK, 32'h80);
      addr(8'h54, 1'b0);
      i_wire_master.xfer(8'ha5, 1'b1, q8, a);
      chk("data ack", 32'h0, {31'h0, a});
      i_wire_master.stop();
      repeat (8) @(posedge sys_clk);
      chk("irq set", 32'h1, {31'h0, irq});
      wr(`ADDR_MASK, 32'h0);
      repeat (3) @(posedge sys_clk);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(`ADDR_MASK, 32'h80);
      repeat (3) @(posedge sys_clk);
      chk("irq unmasked", 32'h1, {31'h0, irq});
      rd("st write", `ADDR_STATUS, 32'h196, 32'h1f7);
      repeat (3) @(posedge sys_clk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      rd("rx byte", `ADDR_RXDATA, 32'ha5, 32'hff);
      rd("st cleared", `ADDR_STATUS, 32'h0, 32'h1ff);
      $display("test slave receive done");
      wr(`ADDR_CTRL, 32'h1f);
      wr(`ADDR_TXDATA, 32'h3c);
      addr(8'h55, 1'b0);
      fork
         i_wire_master.xfer(8'hff, 1'b1, q8, a);
         begin
            repeat (20) @(posedge sys_clk);
            chk("stretch", 32'h0, {31'h0, scl});
            rd("st match", `ADDR_STATUS, 32'h31, 32'h1ff);
         end
      join
      chk("tx byte", 32'h3c, {24'h0, q8});
      i_wire_master.start();
      rd("st rep", `ADDR_STATUS, 32'h4c, 32'h1df);
      i_wire_master.xfer(8'h2a, 1'b1, q8, a);
      i_wire_master.stop();
      $display("test slave transmit done");
      @(posedge sys_clk);
      resetn <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk("rst drive", 32'h3, {30'h0, s_drv});
      chk("rst wake", 32'h0, {31'h0, wreq});
      resetn <= 1'b1;
      rd("rst ctrl", `ADDR_CTRL, 32'h0, 32'h3f);
      chk("master hang", 32'h0, 32'(i_wire_master.stuck));
      $display("test reset done");
      end_sim();
   end
endmodule
